/* dv/testbench.sv */
// Self-checking bench for the comparator and reference-ladder control block.
// Assumes cvc_top and cvc_pkg are compiled first; a bench model is compared every cycle.
`timescale 1ns/1ps
`default_nettype none

module testbench;
  // Design ports
  logic       i_mclk;
  logic       i_rstn;
  logic [3:0] i_addr;
  logic [7:0] i_wdata;
  logic       i_wr;
  logic       i_rd;
  logic [2:0] i_cmp_raw;
  logic [7:0] o_rdata;
  logic [2:0] o_on;
  logic [2:0] o_oe;
  logic [2:0] o_ref;
  logic [5:0] o_ch;
  logic [2:0] o_out;
  logic       o_lpwr;
  logic       o_loe;
  logic       o_lss;
  logic [4:0] o_llvl;
  logic       o_wake;
  logic       o_irqh;
  logic       o_irql;
  // Bench model state
  logic [7:0] m_ctl [3];
  logic [2:0] m_flag, m_en, m_prio, m_out, cur, hit;
  logic [7:0] m_vref, m_rd;
  int         fail_count, samples_checked, cyc, i, k;
  logic [31:0] seed, r;

  cvc_top u_dut (.i_mclk(i_mclk), .i_rstn(i_rstn), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
    .i_rd(i_rd), .o_rdata(o_rdata), .i_cmp_raw(i_cmp_raw), .o_comparator_on(o_on),
    .o_comparator_pin_drive_enable(o_oe), .o_plus_input_ref_select(o_ref), .o_minus_input_channel(o_ch),
    .o_cmp_out(o_out), .o_ladder_power_on(o_lpwr), .o_ladder_pin_output_enable(o_loe),
    .o_ladder_source_select(o_lss), .o_ladder_level_code(o_llvl), .o_wake_req(o_wake),
    .o_irq_high(o_irqh), .o_irq_low(o_irql));

  // Clock at 40 MHz
  initial
  begin
    i_mclk = 1'b0;
    forever #12.5 i_mclk = ~i_mclk;
  end

  // Model: events use the control value held before this edge, so a write never races its own event
  always @(posedge i_mclk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      m_ctl = '{default: 8'h00};
      m_flag = 3'h0;
      m_en = 3'h0;
      m_prio = 3'h0;
      m_out = 3'h0;
      m_vref = 8'h00;
      m_rd = 8'h00;
    end
    else
    begin
      for (i = 0; i < 3; i++)
      begin
        cur[i] = m_ctl[i][7] & (i_cmp_raw[i] ^ m_ctl[i][5]);
        case (m_ctl[i][4:3])
          2'h1: hit[i] = cur[i] & ~m_out[i];
          2'h2: hit[i] = ~cur[i] & m_out[i];
          2'h3: hit[i] = cur[i] ^ m_out[i];
          default: hit[i] = 1'b0;
        endcase
      end
      m_rd = 8'h00;
      if (i_rd)
        case (i_addr)
          4'h0, 4'h1, 4'h2: m_rd = m_ctl[i_addr];
          4'h3: m_rd = {5'h00, m_flag};
          4'h4: m_rd = {5'h00, m_en};
          4'h5: m_rd = {5'h00, m_prio};
          4'h6: m_rd = {m_out, 5'h00};
          4'h7: m_rd = m_vref;
          default: m_rd = 8'h00;
        endcase
      if (i_wr)
        case (i_addr)
          4'h0, 4'h1, 4'h2: m_ctl[i_addr] = i_wdata;
          4'h3: m_flag = i_wdata[2:0];
          4'h4: m_en = i_wdata[2:0];
          4'h5: m_prio = i_wdata[2:0];
          4'h7: m_vref = i_wdata;
          default: ;
        endcase
      m_flag = m_flag | hit;
      m_out = cur;
    end
  end

  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    samples_checked++;
    if (g !== e)
    begin
      fail_count++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask

  // Outputs are settled at the falling edge
  always @(negedge i_mclk)
  begin
    chk("rdata", m_rd, o_rdata);
    chk("ladder", m_vref, {o_lpwr, o_loe, o_lss, o_llvl});
    chk("on_oe", {2'h0, m_ctl[2][7], m_ctl[1][7], m_ctl[0][7], m_ctl[2][6], m_ctl[1][6], m_ctl[0][6]},
        {2'h0, o_on, o_oe});
    chk("ref_ch", {m_ctl[2][2], m_ctl[1][2], m_ctl[0][2], 5'h00}, {o_ref, 5'h00});
    chk("chan", {2'h0, m_ctl[2][1:0], m_ctl[1][1:0], m_ctl[0][1:0]}, {2'h0, o_ch});
    chk("out_req", {2'h0, m_out, |(m_flag & m_en), |(m_flag & m_en & m_prio), |(m_flag & m_en & ~m_prio)},
        {2'h0, o_out, o_wake, o_irqh, o_irql});
  end

  task automatic bus(input logic w, input logic rd, input logic [3:0] a, input logic [7:0] d);
    i_wr <= w;
    i_rd <= rd;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_mclk);
  endtask

  task automatic test_done;
    $display("Checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // Random traffic: register writes and reads mixed with raw comparator changes
  task automatic rnd(input int n);
    repeat (n)
    begin
      r = $random(seed);
      i_cmp_raw <= r[18:16];
      bus(r[0] & r[1], r[0] & ~r[1], r[7:4], r[15:8]);
    end
  endtask

  // Hang guard
  always @(posedge i_mclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 6000)
    begin
      fail_count++;
      test_done;
    end
  end

  initial
  begin
    seed = 32'hC15E5F73;
    {i_rstn, i_wr, i_rd, i_addr, i_wdata, i_cmp_raw} = '0;
    {fail_count, samples_checked, cyc} = '0;
    repeat (4) @(posedge i_mclk);
    i_rstn <= 1'b1;
    @(posedge i_mclk);
    // Every index written with ones then read, unmapped and read-only ones included
    for (k = 0; k < 16; k++)
    begin
      bus(1'b0, 1'b1, k[3:0], 8'h00);
      bus(1'b1, 1'b0, k[3:0], 8'hFF);
      bus(1'b0, 1'b1, k[3:0], 8'h00);
    end
    // All 32 level codes with random power, pin and source bits
    for (k = 0; k < 32; k++)
    begin
      r = $random(seed);
      bus(1'b1, 1'b0, 4'h7, {r[2:0], k[4:0]});
      bus(1'b0, 1'b1, 4'h7, 8'h00);
    end
    // Each select code and polarity; the edge lands with a flag-clearing write
    for (k = 0; k < 8; k++)
    begin
      bus(1'b1, 1'b0, 4'h0, {2'h2, k[2], k[1:0], 3'h5});
      bus(1'b1, 1'b0, 4'h4, 8'h01);
      i_cmp_raw <= 3'h1;
      bus(1'b1, 1'b0, 4'h3, 8'h00);
      bus(1'b0, 1'b1, 4'h3, 8'h00);
      i_cmp_raw <= 3'h0;
      bus(1'b0, 1'b0, 4'h0, 8'h00);
      bus(1'b0, 1'b1, 4'h3, 8'h00);
    end
    // Before a notional sleep, software turns every comparator and the ladder off
    for (k = 0; k < 3; k++)
      bus(1'b1, 1'b0, k[3:0], 8'h00);
    bus(1'b1, 1'b0, 4'h7, 8'h00);
    bus(1'b0, 1'b0, 4'h0, 8'h00);
    @(negedge i_mclk);
    chk("sleep_off", 8'h00, {o_on, o_lpwr, o_loe, 3'h0});
    @(posedge i_mclk);
    rnd(1500);
    // Reset in mid-run
    i_rstn <= 1'b0;
    bus(1'b0, 1'b0, 4'h0, 8'h00);
    i_rstn <= 1'b1;
    rnd(1500);
    test_done;
  end
endmodule

`default_nettype wire

/* rtl/cvc_params.svh */
// Register indexes, field positions and reset values of the comparator and reference-ladder control block.
// Included by the package and by the block itself; holds definitions only.
`ifndef CVC_PARAMS_SVH
`define CVC_PARAMS_SVH

// Register indexes on the plain register port
`define CVC_IDX_CMP1   4'h0
`define CVC_IDX_CMP2   4'h1
`define CVC_IDX_CMP3   4'h2
`define CVC_IDX_FLAGS  4'h3
`define CVC_IDX_ENAB   4'h4
`define CVC_IDX_PRIO   4'h5
`define CVC_IDX_STAT   4'h6
`define CVC_IDX_LADDER 4'h7

// Comparator control fields
`define CVC_F_ON     7
`define CVC_F_OE     6
`define CVC_F_POL    5
`define CVC_F_EV_HI  4
`define CVC_F_EV_LO  3
`define CVC_F_REF    2
`define CVC_F_CH_HI  1
`define CVC_F_CH_LO  0

// Ladder control fields
`define CVC_L_PWR    7
`define CVC_L_OE     6
`define CVC_L_SS     5
`define CVC_L_LVL_HI 4
`define CVC_L_LVL_LO 0

// Status field: comparator outputs occupy bits 7:5
`define CVC_S_LO     5
`define CVC_S_HI     7

// Reset values
`define CVC_CTL_RST    8'h00
`define CVC_LADDER_RST 8'h00
`define CVC_BITS_RST   3'h0

`endif

/* rtl/cvc_pkg.sv */
// Types of the comparator and reference-ladder control block.
// Assumes cvc_params.svh is on the include path.
`include "cvc_params.svh"

package cvc_pkg;

  // Edge event selection codes
  typedef enum logic [1:0] {
    CVC_EV_NONE = 2'h0,
    CVC_EV_RISE = 2'h1,
    CVC_EV_FALL = 2'h2,
    CVC_EV_ANY  = 2'h3
  } cvc_evsel_t;

  // Whole state of the block
  typedef struct packed {
    logic [2:0][7:0] ctl;   // Per-comparator control
    logic [2:0]      flag;  // Event flags
    logic [2:0]      en;    // Event enables
    logic [2:0]      prio;  // Event priorities
    logic [7:0]      vref;  // Ladder control
    logic [2:0]      outv;  // Comparator outputs after inversion
    logic [7:0]      rdata; // Read answer
    logic            wake;  // Wake request
    logic            irqh;  // High priority request
    logic            irql;  // Low priority request
  } cvc_state_t;

endpackage

/* rtl/cvc_top.sv */
// Control logic for three comparators and a 32-level reference ladder.
// Assumes synchronous comparator inputs and one register access per cycle.
`timescale 1ns/1ps
`default_nettype none
`include "cvc_params.svh"

module cvc_top
  import cvc_pkg::*;
(
  // Clock and reset
  input  wire logic       i_mclk,
  input  wire logic       i_rstn,
  // Register port
  input  wire logic [3:0] i_addr,
  input  wire logic [7:0] i_wdata,
  input  wire logic       i_wr,
  input  wire logic       i_rd,
  output logic      [7:0] o_rdata,
  // Analog comparator raw outputs
  input  wire logic [2:0] i_cmp_raw,
  // Comparator controls toward the analog side, and the registered comparator outputs
  output logic      [2:0] o_comparator_on,
  output logic      [2:0] o_comparator_pin_drive_enable,
  output logic      [2:0] o_plus_input_ref_select,
  output logic      [5:0] o_minus_input_channel,
  output logic      [2:0] o_cmp_out,
  // Ladder controls toward the analog side
  output logic            o_ladder_power_on,
  output logic            o_ladder_pin_output_enable,
  output logic            o_ladder_source_select,
  output logic      [4:0] o_ladder_level_code,
  // Requests toward the interrupt controller and power manager
  output logic            o_wake_req,
  output logic            o_irq_high,
  output logic            o_irq_low
);

  cvc_state_t q;
  cvc_state_t d;

  logic [2:0] cur;
  logic [2:0] evt;

  // Per-comparator output and edge event; an off comparator reads low
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++)
    begin : g_cmp
      cvc_evsel_t sel;
      assign sel     = cvc_evsel_t'(q.ctl[gi][`CVC_F_EV_HI:`CVC_F_EV_LO]);
      assign cur[gi] = q.ctl[gi][`CVC_F_ON] & (i_cmp_raw[gi] ^ q.ctl[gi][`CVC_F_POL]);
      // Edges are taken against the last registered output, so no clock-gating depends on sleep
      always_comb
      begin
        case (sel)
          CVC_EV_RISE: evt[gi] = cur[gi] & ~q.outv[gi];
          CVC_EV_FALL: evt[gi] = ~cur[gi] & q.outv[gi];
          CVC_EV_ANY:  evt[gi] = cur[gi] ^ q.outv[gi];
          default:     evt[gi] = 1'b0;
        endcase
      end
    end
  endgenerate

  // Next state: register writes, sticky flags, read answer and requests
  always_comb
  begin
    d = q;
    d.outv = cur;
    // Sleep is not an input here: nothing is altered by entering or leaving it
    if (i_wr)
    begin
      case (i_addr)
        `CVC_IDX_CMP1:   d.ctl[0] = i_wdata;
        `CVC_IDX_CMP2:   d.ctl[1] = i_wdata;
        `CVC_IDX_CMP3:   d.ctl[2] = i_wdata;
        `CVC_IDX_FLAGS:  d.flag   = i_wdata[2:0];
        `CVC_IDX_ENAB:   d.en     = i_wdata[2:0];
        `CVC_IDX_PRIO:   d.prio   = i_wdata[2:0];
        `CVC_IDX_LADDER: d.vref   = i_wdata;
        default:         d.flag   = d.flag;
      endcase
    end
    // A hardware event wins over a clear written in the same cycle
    d.flag = d.flag | evt;
    d.rdata = 8'h00;
    if (i_rd)
    begin
      case (i_addr)
        `CVC_IDX_CMP1:   d.rdata = q.ctl[0];
        `CVC_IDX_CMP2:   d.rdata = q.ctl[1];
        `CVC_IDX_CMP3:   d.rdata = q.ctl[2];
        `CVC_IDX_FLAGS:  d.rdata = {5'h00, q.flag};
        `CVC_IDX_ENAB:   d.rdata = {5'h00, q.en};
        `CVC_IDX_PRIO:   d.rdata = {5'h00, q.prio};
        `CVC_IDX_STAT:   d.rdata = {q.outv, 5'h00};
        `CVC_IDX_LADDER: d.rdata = q.vref;
        default:         d.rdata = 8'h00;
      endcase
    end
    // Wake needs no global enable; priority split feeds the interrupt controller
    d.wake = |(d.flag & d.en);
    d.irqh = |(d.flag & d.en & d.prio);
    d.irql = |(d.flag & d.en & ~d.prio);
  end

  // State register; reset turns every comparator and the ladder off
  always_ff @(posedge i_mclk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      q.ctl   <= {3{`CVC_CTL_RST}};
      q.flag  <= `CVC_BITS_RST;
      q.en    <= `CVC_BITS_RST;
      q.prio  <= `CVC_BITS_RST;
      q.vref  <= `CVC_LADDER_RST;
      q.outv  <= `CVC_BITS_RST;
      q.rdata <= 8'h00;
      q.wake  <= 1'b0;
      q.irqh  <= 1'b0;
      q.irql  <= 1'b0;
    end
    else
    begin
      q <= d;
    end
  end

  // Outputs straight from the state flops
  generate
    for (gi = 0; gi < 3; gi++)
    begin : g_out
      assign o_comparator_on[gi]               = q.ctl[gi][`CVC_F_ON];
      assign o_comparator_pin_drive_enable[gi] = q.ctl[gi][`CVC_F_OE];
      assign o_plus_input_ref_select[gi]       = q.ctl[gi][`CVC_F_REF];
      assign o_minus_input_channel[2*gi+1 -: 2] = q.ctl[gi][`CVC_F_CH_HI:`CVC_F_CH_LO];
    end
  endgenerate

  // Ladder controls act whatever the comparators do
  assign o_ladder_power_on          = q.vref[`CVC_L_PWR];
  assign o_ladder_pin_output_enable = q.vref[`CVC_L_OE];
  assign o_ladder_source_select     = q.vref[`CVC_L_SS];
  assign o_ladder_level_code        = q.vref[`CVC_L_LVL_HI:`CVC_L_LVL_LO];
  assign o_cmp_out                  = q.outv;
  assign o_rdata                    = q.rdata;
  assign o_wake_req                 = q.wake;
  assign o_irq_high                 = q.irqh;
  assign o_irq_low                  = q.irql;

  // Checks

  property p_rise_sets;
    @(posedge i_mclk) disable iff (!i_rstn)
    (q.ctl[0][`CVC_F_EV_HI:`CVC_F_EV_LO] == CVC_EV_RISE && cur[0] && !q.outv[0]) |=> q.flag[0];
  endproperty
  a_rise_sets: assert property (p_rise_sets) else $error("rising edge did not set flag");

  property p_none_quiet;
    @(posedge i_mclk) disable iff (!i_rstn)
    (q.ctl[0][`CVC_F_EV_HI:`CVC_F_EV_LO] == CVC_EV_NONE && !q.flag[0]
     && !(i_wr && i_addr == `CVC_IDX_FLAGS)) |=> !q.flag[0];
  endproperty
  a_none_quiet: assert property (p_none_quiet) else $error("flag set with events off");

  property p_sticky;
    @(posedge i_mclk) disable iff (!i_rstn)
    (q.flag[1] && !(i_wr && i_addr == `CVC_IDX_FLAGS)) |=> q.flag[1];
  endproperty
  a_sticky: assert property (p_sticky) else $error("flag dropped without a clear");

  property p_sw_set;
    @(posedge i_mclk) disable iff (!i_rstn)
    (i_wr && i_addr == `CVC_IDX_FLAGS && i_wdata[2]) |=> q.flag[2];
  endproperty
  a_sw_set: assert property (p_sw_set) else $error("software set of flag lost");

  property p_wake;
    @(posedge i_mclk) disable iff (!i_rstn)
    o_wake_req == |(q.flag & q.en);
  endproperty
  a_wake: assert property (p_wake) else $error("wake request mismatch");

  property p_status;
    @(posedge i_mclk) disable iff (!i_rstn)
    (i_rd && i_addr == `CVC_IDX_STAT) |=> o_rdata[`CVC_S_HI:`CVC_S_LO] == $past(q.outv) && o_rdata[4:0] == 5'h00;
  endproperty
  a_status: assert property (p_status) else $error("status read wrong");

  property p_ladder_hold;
    @(posedge i_mclk) disable iff (!i_rstn)
    !(i_wr && i_addr == `CVC_IDX_LADDER) |=> $stable(q.vref);
  endproperty
  a_ladder_hold: assert property (p_ladder_hold) else $error("ladder control changed unbidden");

  property p_ladder_write;
    @(posedge i_mclk) disable iff (!i_rstn)
    (i_wr && i_addr == `CVC_IDX_LADDER) |=> o_ladder_power_on == $past(i_wdata[7])
      && o_ladder_pin_output_enable == $past(i_wdata[6]) && o_ladder_source_select == $past(i_wdata[5])
      && o_ladder_level_code == $past(i_wdata[4:0]);
  endproperty
  a_ladder_write: assert property (p_ladder_write) else $error("ladder write not applied");

  property p_ctl_hold;
    @(posedge i_mclk) disable iff (!i_rstn)
    !(i_wr && i_addr == `CVC_IDX_CMP1) |=> $stable(q.ctl[0]);
  endproperty
  a_ctl_hold: assert property (p_ctl_hold) else $error("comparator control changed unbidden");

  property p_reset_off;
    @(posedge i_mclk)
    !$past(i_rstn) |-> (o_comparator_on == 3'h0 && !o_ladder_power_on && !o_ladder_pin_output_enable);
  endproperty
  a_reset_off: assert property (p_reset_off) else $error("reset left a unit on");

  c_rise:  cover property (@(posedge i_mclk) disable iff (!i_rstn) evt[0] && q.outv[0] == 1'b0);
  c_any:   cover property (@(posedge i_mclk) disable iff (!i_rstn)
                           q.ctl[1][`CVC_F_EV_HI:`CVC_F_EV_LO] == CVC_EV_ANY && evt[1]);
  c_wake:  cover property (@(posedge i_mclk) disable iff (!i_rstn) $rose(o_wake_req));
  c_clash: cover property (@(posedge i_mclk) disable iff (!i_rstn)
                           i_wr && i_addr == `CVC_IDX_FLAGS && evt[0] && !i_wdata[0]);

endmodule
`default_nettype wire
